// File: logic/msd_status.sv
// modulator status, interrupts, fifo flags and spi burst debug
`timescale 1ns/1ps
// Functional notes
// - burst read drives sdo, two idle bits first
// - any number of words, 2-8 termination bits
// - debug registers change only after 56 burst bits
// - checksum sums burst write words after first
// - counts auto increments and sclk edges
// - three wire: sdo high-z on writes
// - async reset, synchronised release per clock
// - broadcast gain writes overwrite all channels
// - symbol match live and latched status
// - select 0x05 puts match on test pin
// - all sources enabled; global enable gates all
// - interrupt output active low, informative only
// - one mode selects event or level detection
// - writing zero clears interrupt source bit
// - write to full fifo sets overflow bit
// - ready low below seven free, slack accepted
// - empty read underflows; muted channels never flag
// - over-capacity unmute refused, sets capacity bit
// - phase error when sync capture violated
// - even parity checks on ports and converter
// - flags on dll lock and test mode
// - multi-address flag selects burst access
// - each further word goes to next address
module msd_status #(
  parameter int CAPACITY    = 160,
  parameter int DEFAULT_CFG = 0
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic         ofdm_port_clock_in,
  input  wire logic         port_sync_in,
  input  wire logic [8:0]   port_bc_sym_in,
  input  wire logic         port_bc_par_in,
  input  wire logic         port_bc_valid_in,
  input  wire logic         spi_sclk_in,
  input  wire logic         spi_ss_n_in,
  input  wire logic         spi_sdi_in,
  input  wire logic [3:0]   pkg_addr_in,
  input  wire logic         fifo_wr_en_in,
  input  wire logic [7:0]   fifo_wr_ch_in,
  input  wire logic         fifo_rd_en_in,
  input  wire logic [7:0]   fifo_rd_ch_in,
  input  wire logic [9:0]   fifo_rd_sym_in,
  input  wire logic         port_a_valid_in,
  input  wire logic [9:0]   port_a_sym_in,
  input  wire logic         port_a_par_in,
  input  wire logic         dac_parity_err_in,
  input  wire logic         dll_lock_in,
  output logic              sdo_out,
  output logic              sdo_oe_out,
  output logic              irq_n_out,
  output logic              debug_test_output_out,
  output logic [159:0]      chan_ready_out
);
  localparam int LIMIT = (CAPACITY > DEFAULT_CFG) ? CAPACITY : DEFAULT_CFG;

  typedef struct packed {
    logic [2:0] sclk_s, lock_s, ph_s, par_s;
    logic [1:0] ss_s, sdi_s;
    logic [1:0][3:0] pkg_s;
    msd_pkg::msd_spi_st_type st;
    logic [4:0] bitn;
    logic [19:0] hdr;
    logic rw, multi, sel, pend, pcnt, past56, sdo, sdo_oe;
    logic [10:0] cur_addr, wa_hold;
    logic [31:0] wsh, rsh, wd_hold, chksum;
    logic [15:0] dbg_edges, dbg_inc;
    logic [3:0] gcfg, test_sel;
    logic [9:0] irq_en, flg, cond_q;
    logic test_mode;
    logic [159:0][7:0] g1;
    logic [159:0][10:0] g2;
    logic [159:0][4:0] cnt;
    logic [159:0] mute, ovf, unf, ready;
    logic [7:0] active, ch_sel, sym_ch;
    logic cce, sym_irq_en, live, lat, debug_test_output, irq_n;
    logic [9:0] expected_symbol;
  } msd_core_type;

  typedef struct packed {
    logic rise1, rise2, neg2, neg3;
    logic [8:0] sym1, sym2;
    logic par1, par2, val1, val2;
    logic [1:0] en_ph, en_par;
    logic ph_tg, par_tg;
  } msd_port_type;

  msd_core_type r, n;
  msd_port_type p, pn;
  logic [1:0] rst_core_r, rst_port_r;
  logic neg_cap_r;
  logic core_rst_n, port_rst_n;

  ////////////////////////////////////////////////////////////////////////////
  // reset release per domain; assertion stays asynchronous
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) rst_core_r <= 2'h0;
    else rst_core_r <= {rst_core_r[0], 1'b1};
  end
  // port domain release needs a running port clock
  always_ff @(posedge ofdm_port_clock_in or negedge nrst_in) begin
    if (!nrst_in) rst_port_r <= 2'h0;
    else rst_port_r <= {rst_port_r[0], 1'b1};
  end
  assign core_rst_n = rst_core_r[1];
  assign port_rst_n = rst_port_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // port domain: sync capture check and b/c parity
  always_ff @(negedge ofdm_port_clock_in or negedge port_rst_n) begin
    if (!port_rst_n) neg_cap_r <= 1'b0;
    else neg_cap_r <= port_sync_in;
  end

  always_comb begin
    pn = p;
    pn.rise1 = port_sync_in;  // capture on rising edge
    pn.rise2 = p.rise1;
    pn.neg2 = neg_cap_r;
    pn.neg3 = p.neg2;
    pn.sym1 = port_bc_sym_in;
    pn.sym2 = p.sym1;
    pn.par1 = port_bc_par_in;
    pn.par2 = p.par1;
    pn.val1 = port_bc_valid_in;
    pn.val2 = p.val1;
    pn.en_ph = {p.en_ph[0], r.irq_en[msd_pkg::SRC_PHASE]};
    pn.en_par = {p.en_par[0], r.gcfg[msd_pkg::GCFG_PBC_PAR]};
    // sync moved late in the cycle: half-cycle sample disagrees
    if (p.en_ph[1] && (p.rise2 != p.neg3)) pn.ph_tg = ~p.ph_tg;
    if (p.en_par[1] && p.val2 && (^{p.sym2, p.par2})) pn.par_tg = ~p.par_tg;
  end

  always_ff @(posedge ofdm_port_clock_in or negedge port_rst_n) begin
    if (!port_rst_n) p <= '0;
    else p <= pn;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read decode, shared by spi read paths
  function automatic logic [31:0] reg_read(input logic [10:0] a);
    logic [31:0] d;
    logic [7:0] c;
    d = 32'h0;
    c = r.ch_sel;
    if (a == msd_pkg::OFS_DBG_CNT) d = {r.dbg_inc, r.dbg_edges};
    else if (a == msd_pkg::OFS_CHKSUM) d = r.chksum;
    else if (a == msd_pkg::OFS_GCFG) d = {28'h0, r.gcfg};
    else if (a == msd_pkg::OFS_IRQ_EN) d = {22'h0, r.irq_en};
    else if (a == msd_pkg::OFS_INTCTL) d = {22'h0, r.flg};
    else if (a == msd_pkg::OFS_TEST) d = {23'h0, r.test_mode, 4'h0, r.test_sel};
    else if (a == msd_pkg::OFS_CH_SEL) d = {24'h0, c};
    else if (a == msd_pkg::OFS_CH_STAT && c < 8'(msd_pkg::NUM_CH))
      d = {r.unf[c], r.ovf[c], r.mute[c], r.ready[c], 3'h0, r.cnt[c], r.g2[c], r.g1[c]};
    else if (a == msd_pkg::OFS_ACTIVE) d = {23'h0, r.cce, r.active};
    else if (a == msd_pkg::OFS_SYM)
      d = {2'h0, r.lat, r.live, 3'h0, r.sym_irq_en, r.sym_ch, 6'h0, r.expected_symbol};
    return d;
  endfunction : reg_read

  ////////////////////////////////////////////////////////////////////////////
  // core next state
  always_comb begin
    logic rise, we;
    logic [31:0] rd, wd;
    logic [10:0] wa;
    logic [9:0] clr, set, cond;
    logic [7:0] mc;
    logic any_ovf, any_unf, hit;
    rise = 1'b0; we = 1'b0; rd = 32'h0; wd = 32'h0; wa = 11'h0;
    clr = 10'h0; set = 10'h0; cond = 10'h0; mc = 8'h0;
    any_ovf = 1'b0; any_unf = 1'b0; hit = 1'b0;
    n = r;
    // input synchronisers, first stage read only by second
    n.sclk_s = {r.sclk_s[1:0], spi_sclk_in};
    n.ss_s = {r.ss_s[0], spi_ss_n_in};
    n.sdi_s = {r.sdi_s[0], spi_sdi_in};
    n.lock_s = {r.lock_s[1:0], dll_lock_in};
    n.pkg_s = {r.pkg_s[0], pkg_addr_in};
    n.ph_s = {r.ph_s[1:0], p.ph_tg};
    n.par_s = {r.par_s[1:0], p.par_tg};
    rise = r.sclk_s[1] & ~r.sclk_s[2];

    // spi frame
    if (r.ss_s[1]) begin
      n.st = msd_pkg::st_hdr;
      n.bitn = 5'h0;
      n.pend = 1'b0;
      n.past56 = 1'b0;
      n.sdo_oe = 1'b0;
      n.sdo = 1'b0;
    end else if (rise) begin
      if (r.past56) n.dbg_edges = r.dbg_edges + 16'h0001;
      // a word commits two edges after its last bit
      if (r.pend) begin
        n.pcnt = 1'b1;
        if (r.pcnt) begin
          n.pend = 1'b0;
          we = r.sel & ~r.rw;
          wa = r.wa_hold;
          wd = r.wd_hold;
        end
      end
      n.bitn = r.bitn + 5'h1;
      case (r.st)
        msd_pkg::st_hdr: begin
          n.hdr = {r.hdr[18:0], r.sdi_s[1]};
          if (r.bitn == msd_pkg::ADDR_DONE) begin
            n.rw = n.hdr[msd_pkg::RW_POS];
            n.multi = n.hdr[msd_pkg::MULTI_POS];
            n.sel = (n.hdr[msd_pkg::PKG_LSB +: 4] == r.pkg_s[1]);
            n.cur_addr = n.hdr[10:0];
            n.sdo_oe = n.rw & n.sel;
            n.sdo = 1'b0;
          end
          if (r.bitn == msd_pkg::HDR_DONE) begin
            n.st = msd_pkg::st_word;
            n.bitn = 5'h0;
            rd = reg_read(r.cur_addr);
            n.sdo = rd[31];  // idle bits done, data follows
            n.rsh = {rd[30:0], 1'b0};
          end
        end
        msd_pkg::st_word: begin
          n.wsh = {r.wsh[30:0], r.sdi_s[1]};
          n.sdo = r.rsh[31];
          n.rsh = {r.rsh[30:0], 1'b0};
          if (r.bitn == msd_pkg::WORD_LAST) begin
            n.wd_hold = n.wsh;
            n.wa_hold = r.cur_addr;
            n.pend = 1'b1;
            n.pcnt = 1'b0;
            n.bitn = 5'h0;
            if (r.past56 && !r.rw) n.chksum = r.chksum + n.wsh;
            if (!r.past56) begin
              n.st = msd_pkg::st_gap;
              n.sdo = 1'b0;
            end else begin
              n.cur_addr = r.cur_addr + 11'h001;
              n.dbg_inc = r.dbg_inc + 16'h0001;
              rd = reg_read(n.cur_addr);
              n.sdo = rd[31];
              n.rsh = {rd[30:0], 1'b0};
            end
          end
        end
        msd_pkg::st_gap: begin
          n.sdo = 1'b0;
          if (r.bitn == msd_pkg::GAP_LAST) begin
            n.bitn = 5'h0;
            n.st = msd_pkg::st_idle;
            if (r.multi) begin
              // first 56 bits done: debug registers restart here
              n.st = msd_pkg::st_word;
              n.past56 = 1'b1;
              n.chksum = 32'h0;
              n.dbg_edges = 16'h0;
              n.dbg_inc = 16'h0001;
              n.cur_addr = r.cur_addr + 11'h001;
              rd = reg_read(n.cur_addr);
              n.sdo = rd[31];
              n.rsh = {rd[30:0], 1'b0};
            end
          end
        end
        default: n.sdo = 1'b0;  // termination bits ignored
      endcase
    end

    // register writes
    if (we) begin
      if (wa == msd_pkg::OFS_GCFG) n.gcfg = wd[3:0];
      else if (wa == msd_pkg::OFS_IRQ_EN) n.irq_en = wd[9:0];
      else if (wa == msd_pkg::OFS_INTCTL) clr = ~wd[9:0];
      else if (wa == msd_pkg::OFS_TEST) begin
        n.test_sel = wd[3:0];
        n.test_mode = wd[msd_pkg::TEST_MODE_POS];
      end else if (wa == msd_pkg::OFS_BC_G1) begin
        for (int i = 0; i < msd_pkg::NUM_CH; i++) n.g1[i] = wd[7:0];
      end else if (wa == msd_pkg::OFS_BC_G2) begin
        for (int i = 0; i < msd_pkg::NUM_CH; i++) n.g2[i] = wd[10:0];
      end else if (wa == msd_pkg::OFS_CH_GAIN && r.ch_sel < 8'(msd_pkg::NUM_CH)) begin
        n.g1[r.ch_sel] = wd[7:0];
        n.g2[r.ch_sel] = wd[msd_pkg::G2_LSB +: 11];
      end else if (wa == msd_pkg::OFS_CH_SEL) n.ch_sel = wd[7:0];
      else if (wa == msd_pkg::OFS_MUTE && wd[7:0] < 8'(msd_pkg::NUM_CH)) begin
        mc = wd[7:0];
        if (wd[msd_pkg::MUTE_POS] && !r.mute[mc]) begin
          n.mute[mc] = 1'b1;
          n.active = r.active - 8'h01;
          if (n.active <= 8'(LIMIT)) n.cce = 1'b0;
        end else if (!wd[msd_pkg::MUTE_POS] && r.mute[mc]) begin
          if (r.active >= 8'(CAPACITY)) n.cce = 1'b1;  // refused
          else begin
            n.mute[mc] = 1'b0;
            n.active = r.active + 8'h01;
          end
        end
      end else if (wa == msd_pkg::OFS_SYM) begin
        n.expected_symbol = wd[9:0];
        n.sym_ch = wd[msd_pkg::SYM_CH_LSB +: 8];
        n.sym_irq_en = wd[msd_pkg::SYM_IRQ_POS];
      end
    end

    // channel fifo occupancy, flags and ready
    for (int i = 0; i < msd_pkg::NUM_CH; i++) begin
      logic w, rdv, fo, fu;
      w = fifo_wr_en_in && (fifo_wr_ch_in == 8'(i));
      rdv = fifo_rd_en_in && (fifo_rd_ch_in == 8'(i));
      fo = w && !rdv && (r.cnt[i] == msd_pkg::FIFO_FULL) && !r.mute[i];
      fu = rdv && (r.cnt[i] == 5'h0) && !r.mute[i];
      if (w && !rdv && r.cnt[i] != msd_pkg::FIFO_FULL) n.cnt[i] = r.cnt[i] + 5'h1;
      else if (rdv && !w && r.cnt[i] != 5'h0) n.cnt[i] = r.cnt[i] - 5'h1;
      else if (rdv && w && r.cnt[i] == 5'h0) n.cnt[i] = 5'h1;
      n.ovf[i] = (r.ovf[i] & ~clr[msd_pkg::SRC_OVF]) | fo;
      n.unf[i] = (r.unf[i] & ~clr[msd_pkg::SRC_UNF]) | fu;
      // writes past the threshold still land in the slack
      n.ready[i] = (n.cnt[i] <= msd_pkg::READY_MAX);
      any_ovf = any_ovf | fo;
      any_unf = any_unf | fu;
    end

    // symbol match at the selected channel fifo output
    hit = fifo_rd_en_in && (fifo_rd_ch_in == r.sym_ch);
    if (hit) n.live = (fifo_rd_sym_in == r.expected_symbol);
    n.lat = (r.lat & ~(we && wa == msd_pkg::OFS_SYM && !wd[msd_pkg::SYM_LAT_POS]))
          | (hit && fifo_rd_sym_in == r.expected_symbol);
    n.debug_test_output = (r.test_sel == msd_pkg::TEST_OUTPUT_SELECT_MATCH) & r.live;

    // interrupt sources; set wins over a clearing write
    cond[msd_pkg::SRC_CCE] = r.cce;
    cond[msd_pkg::SRC_LOCK] = r.lock_s[1];
    cond[msd_pkg::SRC_TEST] = r.test_mode;
    cond[msd_pkg::SRC_MATCH] = r.live & r.sym_irq_en;
    n.cond_q = cond;
    set[msd_pkg::SRC_OVF] = any_ovf;
    set[msd_pkg::SRC_UNF] = any_unf;
    set[msd_pkg::SRC_PHASE] = r.ph_s[1] ^ r.ph_s[2];
    set[msd_pkg::SRC_DAC] = dac_parity_err_in;
    set[msd_pkg::SRC_PA_PAR] = port_a_valid_in & r.gcfg[msd_pkg::GCFG_PA_PAR]
                             & (^{port_a_sym_in, port_a_par_in});
    set[msd_pkg::SRC_PBC_PAR] = r.par_s[1] ^ r.par_s[2];
    set = set | (cond & ~r.cond_q & msd_pkg::SRC_LEVEL);
    n.flg = (r.flg & ~clr) | set;
    // level mode mirrors level sources live; pulses stay sticky
    if (!r.gcfg[msd_pkg::GCFG_EVENT])
      n.flg = (n.flg & ~msd_pkg::SRC_LEVEL) | (cond & msd_pkg::SRC_LEVEL);
    // informative only: nothing else reads the output
    n.irq_n = ~(r.gcfg[msd_pkg::GCFG_IRQ_EN] & (|(n.flg & r.irq_en)));
  end

  always_ff @(posedge clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      r <= '0;
      r.gcfg <= msd_pkg::GCFG_RST;
      r.irq_en <= msd_pkg::IRQ_EN_RST;
      r.mute <= {160{1'b1}};
      r.ready <= {160{1'b1}};
      r.irq_n <= 1'b1;
      r.ss_s <= 2'h3;
    end else r <= n;
  end

  assign sdo_out = r.sdo;
  assign sdo_oe_out = r.sdo_oe;
  assign irq_n_out = r.irq_n;
  assign debug_test_output_out = r.debug_test_output;
  assign chan_ready_out = r.ready;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!core_rst_n);

  sequence s_full_write;
    fifo_wr_en_in && !(fifo_rd_en_in && fifo_rd_ch_in == fifo_wr_ch_in)
      && fifo_wr_ch_in < 8'(msd_pkg::NUM_CH) && r.cnt[fifo_wr_ch_in] == msd_pkg::FIFO_FULL;
  endsequence
  sequence s_empty_read;
    fifo_rd_en_in && fifo_rd_ch_in < 8'(msd_pkg::NUM_CH) && r.cnt[fifo_rd_ch_in] == 5'h0;
  endsequence

  a_irq_global_off: assert property (!r.gcfg[msd_pkg::GCFG_IRQ_EN] |=> irq_n_out)
    else $error("interrupt asserted while globally disabled");
  a_ovf_flag_set: assert property (s_full_write ##0 !r.mute[fifo_wr_ch_in]
    |=> r.ovf[$past(fifo_wr_ch_in)] ##1 !irq_n_out || !r.irq_en[msd_pkg::SRC_OVF]
        || !r.gcfg[msd_pkg::GCFG_IRQ_EN])
    else $error("overflow did not raise flag and interrupt");
  a_unf_flag_set: assert property (s_empty_read ##0 !r.mute[fifo_rd_ch_in]
    |=> r.unf[$past(fifo_rd_ch_in)])
    else $error("underflow flag not set");
  a_mute_no_flag: assert property (s_full_write ##0 r.mute[fifo_wr_ch_in]
    ##0 !r.ovf[fifo_wr_ch_in] |=> !r.ovf[$past(fifo_wr_ch_in)])
    else $error("muted channel set overflow");
  a_ready_level: assert property (chan_ready_out[0] == (r.cnt[0] <= msd_pkg::READY_MAX))
    else $error("ready does not follow fifo level");
  a_dto_match: assert property ((r.test_sel == msd_pkg::TEST_OUTPUT_SELECT_MATCH) && r.live
    |=> debug_test_output_out)
    else $error("match not on test output");
  a_sdo_write_hiz: assert property (sdo_oe_out |-> r.rw && r.sel)
    else $error("sdo driven outside a read");
  a_single_dbg_hold: assert property (!r.multi && $stable(r.multi)
    |=> $stable(r.chksum) && $stable(r.dbg_edges) && $stable(r.dbg_inc))
    else $error("debug registers moved in single mode");
  a_event_sticky: assert property (r.gcfg[msd_pkg::GCFG_EVENT] && r.flg[msd_pkg::SRC_LOCK]
    && !(we_clr_lock()) |=> r.flg[msd_pkg::SRC_LOCK])
    else $error("event flag dropped without clear");
  a_gain_bcast: assert property (we_commit() && r.wa_hold == msd_pkg::OFS_BC_G1
    |=> r.g1[0] == $past(r.wd_hold[7:0])
    && r.g1[159] == $past(r.wd_hold[7:0]))
    else $error("broadcast gain not applied");

  // a held word commits on this cycle's synchronised sclk rise
  function automatic logic we_commit();
    return r.pend && r.pcnt && !r.ss_s[1] && r.sclk_s[1] && !r.sclk_s[2] && r.sel && !r.rw;
  endfunction : we_commit

  function automatic logic we_clr_lock();
    return we_commit() && r.wa_hold == msd_pkg::OFS_INTCTL
      && !r.wd_hold[msd_pkg::SRC_LOCK];
  endfunction : we_clr_lock

  a_phase_toggle: assert property (@(posedge ofdm_port_clock_in) disable iff (!port_rst_n)
    p.en_ph[1] && (p.rise2 != p.neg3) |=> p.ph_tg != $past(p.ph_tg))
    else $error("phase error not flagged");
endmodule : msd_status

// File: logic/msd_pkg.sv
// shared constants and types of the modulator status and spi debug block
package msd_pkg;
  localparam int NUM_CH = 160;
  localparam int FIFO_DEPTH = 16;
  localparam int READY_FREE = 7;
  localparam logic [4:0] FIFO_FULL = 5'(FIFO_DEPTH);
  localparam logic [4:0] READY_MAX = 5'(FIFO_DEPTH - READY_FREE);
  // spi framing, in sclk rising edges
  localparam logic [4:0] ADDR_DONE = 5'h13;  // edge that ends the address
  localparam logic [4:0] HDR_DONE  = 5'h15;  // edge that ends the idle bits
  localparam logic [4:0] WORD_LAST = 5'h1f;
  localparam logic [4:0] GAP_LAST  = 5'h01;
  localparam int RW_POS = 19;
  localparam int MULTI_POS = 18;
  localparam int PKG_LSB = 11;
  // register offsets
  localparam logic [10:0] OFS_DBG_CNT  = 11'h006;
  localparam logic [10:0] OFS_CHKSUM   = 11'h007;
  localparam logic [10:0] OFS_GCFG     = 11'h010;
  localparam logic [10:0] OFS_IRQ_EN   = 11'h011;
  localparam logic [10:0] OFS_INTCTL   = 11'h012;
  localparam logic [10:0] OFS_TEST     = 11'h013;
  localparam logic [10:0] OFS_BC_G1    = 11'h014;
  localparam logic [10:0] OFS_BC_G2    = 11'h015;
  localparam logic [10:0] OFS_CH_GAIN  = 11'h016;
  localparam logic [10:0] OFS_CH_SEL   = 11'h017;
  localparam logic [10:0] OFS_CH_STAT  = 11'h018;
  localparam logic [10:0] OFS_MUTE     = 11'h019;
  localparam logic [10:0] OFS_ACTIVE   = 11'h01a;
  localparam logic [10:0] OFS_SYM      = 11'h01b;
  // fields
  localparam int GCFG_IRQ_EN = 0;
  localparam int GCFG_EVENT = 1;
  localparam int GCFG_PA_PAR = 2;
  localparam int GCFG_PBC_PAR = 3;
  localparam logic [3:0] GCFG_RST = 4'h3;
  localparam int TEST_MODE_POS = 8;
  localparam logic [3:0] TEST_OUTPUT_SELECT_MATCH = 4'h5;
  localparam int G2_LSB = 8;
  localparam int MUTE_POS = 8;
  localparam int SYM_CH_LSB = 16;
  localparam int SYM_IRQ_POS = 24;
  localparam int SYM_LIVE_POS = 28;
  localparam int SYM_LAT_POS = 29;
  // interrupt sources
  localparam int SRC_OVF = 0;
  localparam int SRC_UNF = 1;
  localparam int SRC_CCE = 2;
  localparam int SRC_PHASE = 3;
  localparam int SRC_DAC = 4;
  localparam int SRC_LOCK = 5;
  localparam int SRC_PA_PAR = 6;
  localparam int SRC_PBC_PAR = 7;
  localparam int SRC_TEST = 8;
  localparam int SRC_MATCH = 9;
  localparam logic [9:0] SRC_LEVEL = 10'h324;  // cce, lock, test, match
  localparam logic [9:0] IRQ_EN_RST = 10'h3ff;
  typedef enum logic [1:0] {st_hdr, st_word, st_gap, st_idle} msd_spi_st_type;
endpackage : msd_pkg

// File: test/msd_host.sv
// spi host model for the status block: frames, three-wire release
`timescale 1ns/1ps
module msd_host (
  input  wire logic clk_in,
  input  wire logic sdo_in,
  output logic      spi_sclk_out,
  output logic      spi_ss_n_out,
  output logic      spi_sdi_out
);
  logic [31:0] rdq[$];
  bit          bq[$];
  bit          cq[$];
  // idle bus: deselected, clock at rest
  initial begin
    spi_sclk_out = 1'b0;
    spi_ss_n_out = 1'b1;
    spi_sdi_out  = 1'b0;
  end
  ////////////////////////////////////////
  // queue one bit and whether the reply is sampled there
  task automatic put(input bit v, input bit c);
    bq.push_back(v);
    cq.push_back(c);
  endtask : put
  // one whole frame; sclk only moves while selected
  task automatic frame(input bit rd, input bit mul, input logic [3:0] pkg,
                       input logic [10:0] adr, input logic [31:0] wq[$], input int term);
    logic [21:0] hdr;
    logic [31:0] r;
    int          n;
    hdr = {rd, mul, 3'h0, pkg, adr, 2'h0};
    n = 0;
    r = 32'h0;
    rdq = {};
    bq = {};
    cq = {};
    for (int i = 21; i >= 0; i--) put(hdr[i], 1'b0);
    foreach (wq[k]) begin
      if (k == 1) put(1'b0, 1'b0);  // two idle bits after the first word
      if (k == 1) put(1'b0, 1'b0);
      for (int i = 31; i >= 0; i--) put(wq[k][i], rd);
    end
    repeat (term) put(1'b1, 1'b0);
    @(posedge clk_in);
    spi_ss_n_out <= 1'b0;
    foreach (bq[i]) begin
      spi_sclk_out <= 1'b0;
      // line released after the address on reads: toggle, never a stale level
      spi_sdi_out <= (rd && i >= 20) ? ~spi_sdi_out : bq[i];
      repeat (4) @(posedge clk_in);
      if (cq[i]) r = {r[30:0], sdo_in};
      if (cq[i]) n++;
      if (cq[i] && n % 32 == 0) rdq.push_back(r);
      spi_sclk_out <= 1'b1;
      repeat (4) @(posedge clk_in);
    end
    spi_sclk_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    spi_ss_n_out <= 1'b1;
    spi_sdi_out <= ~spi_sdi_out;
    repeat (8) @(posedge clk_in);
  endtask : frame
endmodule : msd_host

// File: test/msd_status_test.sv
// self-checking bench of the modulator status block
`timescale 1ns/1ps
module msd_status_test;
  localparam logic [3:0] PKG = 4'h9;
  logic         clk_in = 1'b0;
  logic         pclk   = 1'b0;
  logic         nrst   = 1'b0;
  logic         wr_en  = 1'b0;
  logic         rd_en  = 1'b0;
  logic         dll    = 1'b0;
  logic         dac    = 1'b0;
  logic         pa_v   = 1'b0;
  logic         pa_p   = 1'b0;
  logic         port_sync  = 1'b0;
  logic         sclk, ss_n, sdi, sdo, sdo_oe, irq_n, debug_test_output;
  logic [7:0]   ch     = 8'h00;
  logic [9:0]   sym    = 10'h000;
  logic [159:0] ready;
  logic [31:0]  seed   = 32'hbc63;
  logic [31:0]  got, w0, w1, w2;
  int           failures = 0;
  int           checks   = 0;
  int           cyc      = 0;
  int           cnt      = 0;
  // capacity of one channel makes the refusal cheap to reach
  msd_status #(.CAPACITY(1), .DEFAULT_CFG(0)) i_msd_status (
    .clk_in(clk_in), .nrst_in(nrst), .ofdm_port_clock_in(pclk), .port_sync_in(port_sync),
    .port_bc_sym_in(9'h000), .port_bc_par_in(1'b0), .port_bc_valid_in(1'b0),
    .spi_sclk_in(sclk), .spi_ss_n_in(ss_n), .spi_sdi_in(sdi), .pkg_addr_in(PKG),
    .fifo_wr_en_in(wr_en), .fifo_wr_ch_in(ch), .fifo_rd_en_in(rd_en), .fifo_rd_ch_in(ch),
    .fifo_rd_sym_in(sym), .port_a_valid_in(pa_v), .port_a_sym_in(sym), .port_a_par_in(pa_p),
    .dac_parity_err_in(dac), .dll_lock_in(dll), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .irq_n_out(irq_n), .debug_test_output_out(debug_test_output), .chan_ready_out(ready));
  // the wire floats unless the block enables it
  msd_host i_msd_host (.clk_in(clk_in), .sdo_in(sdo_oe ? sdo : 1'bz), .spi_sclk_out(sclk),
    .spi_ss_n_out(ss_n), .spi_sdi_out(sdi));
  ////////////////////////////////////////
  // core clock; port clock free-running long before any port data
  always #10 clk_in = ~clk_in;
  initial #1.7 forever #3 pclk = ~pclk;
  // hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) failures++;
    if (g !== e) $display("unexpected value at %0t: got %h exp %h", $time, g, e);
  endtask : chk_reg
  task automatic chk_pin(input logic g, input logic e);
    chk_reg({31'h0, g}, {31'h0, e});
  endtask : chk_pin
  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    i_msd_host.frame(1'b0, 1'b0, PKG, a, '{d}, 2);
  endtask : wr
  task automatic rd(input logic [10:0] a, output logic [31:0] d);
    i_msd_host.frame(1'b1, 1'b0, PKG, a, '{32'h0}, 8);
    d = i_msd_host.rdq[0];
  endtask : rd
  // one fifo write or read pulse, random symbol on the data inputs
  task automatic fifo_op(input bit w, input logic [7:0] c);
    seed = lfsr(seed);
    wr_en <= w;
    rd_en <= ~w;
    ch <= c;
    sym <= seed[9:0];
    @(posedge clk_in);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask : fifo_op
  task automatic report_and_stop();
    if (failures == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(posedge clk_in);
    nrst <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk_pin(irq_n, 1'b1);
    chk_pin(sdo_oe | debug_test_output, 1'b0);
    chk_pin(&ready, 1'b1);
    rd(msd_pkg::OFS_IRQ_EN, got);
    chk_reg(got, 32'h3ff);
    w0 = lfsr(seed);
    w1 = lfsr(w0);
    w2 = lfsr(w1);
    seed = w2;
    // burst over both broadcast gains, then the selected channel gain
    i_msd_host.frame(1'b0, 1'b1, PKG, msd_pkg::OFS_BC_G1, '{w0, w1, w2}, 2);
    wr(msd_pkg::OFS_BC_G1, w1);
    rd(msd_pkg::OFS_CH_STAT, got);
    chk_reg(got & 32'h7ffff, {13'h0, w2[18:8], w1[7:0]});
    rd(msd_pkg::OFS_CHKSUM, got);
    chk_reg(got, w1 + w2);
    fifo_op(1'b0, 8'h01);  // muted channel reads empty: no flag
    wr(msd_pkg::OFS_MUTE, 32'h000);
    wr(msd_pkg::OFS_MUTE, 32'h001);
    rd(msd_pkg::OFS_ACTIVE, got);
    chk_reg(got, 32'h101);
    fifo_op(1'b0, 8'h00);
    // fill past full; ready drops once fewer than seven places are free
    for (int i = 1; i <= 17; i++) begin
      fifo_op(1'b1, 8'h00);
      cnt = (cnt < msd_pkg::FIFO_DEPTH) ? cnt + 1 : cnt;
      chk_pin(ready[0], cnt <= msd_pkg::FIFO_DEPTH - msd_pkg::READY_FREE);
    end
    rd(msd_pkg::OFS_INTCTL, got);
    chk_reg(got, 32'h007);
    chk_pin(irq_n, 1'b0);
    wr(msd_pkg::OFS_INTCTL, 32'h000);
    chk_pin(irq_n, 1'b1);
    // global enable off, then parity, converter, lock and test mode events
    wr(msd_pkg::OFS_GCFG, 32'h006);
    seed = lfsr(seed);
    sym <= seed[9:0];
    pa_p <= ~^seed[9:0];
    {pa_v, dac, dll} <= 3'h7;
    @(posedge clk_in);
    {pa_v, dac} <= 2'h0;
    wr(msd_pkg::OFS_TEST, 32'h100);
    chk_pin(irq_n, 1'b1);
    rd(msd_pkg::OFS_INTCTL, got);
    chk_reg(got, 32'h170);
    wr(msd_pkg::OFS_GCFG, 32'h007);
    chk_pin(irq_n, 1'b0);
    report_and_stop();
  end
endmodule : msd_status_test
